/* hw/sched_pkg.sv */
/*
  Shared constants and types for the channel service scheduler.
  Assumes a single 20 MHz clock and a synchronous active-high reset.
*/
package sched_pkg;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int NUM_CHANNELS    = 16;
  localparam int CHAN_W          = 4;
  localparam int CNT_W           = 8;
  localparam int TRANSITION_CLKS = 10;
  localparam int NOP_CLKS        = 4;
  localparam int PWM_HIGH_CLKS   = 24;
  localparam int PWM_LOW_CLKS    = 2;
  localparam int PERIOD_PULSE_ACCUMULATE_FUNCTION_CLKS       = 44;
  localparam int DIO_CLKS        = 10;
  localparam int PWM_RAM_ACC     = 4;
  localparam int PERIOD_PULSE_ACCUMULATE_FUNCTION_RAM_ACC    = 9;
  localparam int DIO_RAM_ACC     = 4;
  localparam int STALL_MAX_CLKS  = 2;
  localparam int SLOT_COUNT      = 7;
  localparam logic [2:0] SLOT_RESET = 3'h0;

  typedef enum logic [1:0] {PRI_LOW, PRI_MID, PRI_HIGH, PRI_OFF} prio_type;
  typedef enum logic [1:0] {FN_PWM, FN_PERIOD_PULSE_ACCUMULATE_FUNCTION, FN_DIO, FN_NONE} func_type;

  typedef struct packed {
    logic                active;
    logic [CHAN_W-1:0]   channel;
    prio_type            level;
    func_type            func;
    logic                pwm_high;
  } grant_type;

  // slot pattern H M H L H M H
  function automatic prio_type slot_level(input logic [2:0] s);
    prio_type p;
    p = PRI_HIGH;
    if (s == 3'h1 || s == 3'h5) p = PRI_MID;
    else if (s == 3'h3) p = PRI_LOW;
    return p;
  endfunction

  function automatic logic [CNT_W-1:0] service_clks(input func_type f,
                                                     input logic hi);
    logic [CNT_W-1:0] c;
    c = CNT_W'(DIO_CLKS);
    if (f == FN_PWM) c = hi ? CNT_W'(PWM_HIGH_CLKS) : CNT_W'(PWM_LOW_CLKS);
    else if (f == FN_PERIOD_PULSE_ACCUMULATE_FUNCTION) c = CNT_W'(PERIOD_PULSE_ACCUMULATE_FUNCTION_CLKS);
    return c;
  endfunction

  function automatic logic [3:0] ram_accesses(input func_type f,
                                              input logic hi);
    logic [3:0] a;
    a = 4'(DIO_RAM_ACC);
    if (f == FN_PWM) a = hi ? 4'(PWM_RAM_ACC) : 4'h1;
    else if (f == FN_PERIOD_PULSE_ACCUMULATE_FUNCTION) a = 4'(PERIOD_PULSE_ACCUMULATE_FUNCTION_RAM_ACC);
    return a;
  endfunction
endpackage

/* hw/channel_service_scheduler.sv */
/*
  Channel service scheduler: grants a shared microengine to timer
  channels by a seven-slot priority pattern and times each service.
  Assumes request and host inputs are synchronous to clk_i except the
  channel request pulses, which are synchronised here.
*/
`timescale 1ns/1ps
module channel_service_scheduler
  import sched_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [NCH-1:0]                request_i,
  input  wire logic [NCH-1:0]                pwm_edge_i,
  input  wire logic [NCH-1:0]                pwm_level_i,
  input  wire sched_pkg::prio_type [NCH-1:0] level_i,
  input  wire sched_pkg::func_type [NCH-1:0] func_i,
  input  wire logic                          host_ram_req_i,
  output logic                               host_ram_grant_o,
  output logic                               engine_ram_o,
  output logic                               stall_o,
  output sched_pkg::grant_type               grant_o,
  output logic                               nop_o,
  output logic                               transition_o,
  output logic [NCH-1:0]                     service_request_latch_o,
  output logic [NCH-1:0]                     service_grant_latch_o
);
  import sched_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SERVICE, ST_NOP, ST_TRANS}
    state_type;

  state_type        state;
  logic [2:0]       slot;
  logic [CNT_W-1:0] cnt;
  logic [3:0]       ram_left;
  logic [NCH-1:0]   req_s1, req_s2, edge_s1, edge_s2, lvl_s1, lvl_s2;
  logic [NCH-1:0]   service_request_latch, service_grant_latch;
  logic             host_busy;
  logic [1:0]       stall_cnt;
  grant_type        cur;
  logic             clear_group;
  logic             pausing;
  logic             transiting;

  function automatic logic [NCH-1:0] level_mask(input prio_type p);
    logic [NCH-1:0] m;
    m = '0;
    for (int i = 0; i < NCH; i++) m[i] = (level_i[i] == p);
    return m;
  endfunction

  function automatic logic [CHAN_W:0] first_set(input logic [NCH-1:0] v);
    logic [CHAN_W:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--)
      if (v[i]) r = {1'b1, CHAN_W'(i)};
    return r;
  endfunction

  // eligible: request set, grant clear
  wire logic [NCH-1:0] eligible = service_request_latch & ~service_grant_latch;
  wire prio_type       slot_pri = slot_level(slot);
  wire logic [NCH-1:0] at_slot  = eligible & level_mask(slot_pri);
  wire logic [NCH-1:0] at_high  = eligible & level_mask(PRI_HIGH);
  wire logic [NCH-1:0] at_mid   = eligible & level_mask(PRI_MID);
  wire logic [NCH-1:0] at_low   = eligible & level_mask(PRI_LOW);
  wire logic [CHAN_W:0] pick_slot = first_set(at_slot);
  wire logic [CHAN_W:0] pick_pass = (|at_high) ? first_set(at_high) :
                                    (|at_mid)  ? first_set(at_mid)  :
                                                 first_set(at_low);
  wire logic [CHAN_W:0] pick = pick_slot[CHAN_W] ? pick_slot : pick_pass;
  wire logic [CHAN_W-1:0] pick_ch = pick[CHAN_W-1:0];
  wire logic [NCH-1:0] cur_grp   = level_mask(cur.level);
  wire logic           group_idle = ~|(eligible & cur_grp);
  // pwm request at each output edge, whatever level it ended
  wire logic [NCH-1:0] ask = req_s2 | edge_s2;

  // engine wants RAM while accesses remain in its service state
  wire logic eng_want = (state == ST_SERVICE) && (ram_left != 4'h0);
  // host wins only if the engine is not already on the RAM, and never
  // straight after its own hold, so an engine stall stays bounded
  wire logic host_win = host_ram_req_i && !engine_ram_o
                        && !host_ram_grant_o;
  wire logic eng_stall = eng_want && (host_busy || host_win);
  wire logic service_done = (state == ST_SERVICE) && (cnt <= 8'h1)
                            && !eng_stall;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_s1 <= '0;
      req_s2 <= '0;
      edge_s1 <= '0;
      edge_s2 <= '0;
      lvl_s1 <= '0;
      lvl_s2 <= '0;
    end else begin
      req_s1 <= request_i;
      req_s2 <= req_s1;
      edge_s1 <= pwm_edge_i;
      edge_s2 <= edge_s1;
      lvl_s1 <= pwm_level_i;
      lvl_s2 <= lvl_s1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      service_request_latch <= '0;
      service_grant_latch <= '0;
    end else begin
      // new requests win over the grant-time clear
      service_request_latch <= (service_request_latch & ~((state == ST_IDLE && pick[CHAN_W]) ?
              (NCH'(1) << pick_ch) : '0)) | ask;
      if (clear_group) service_grant_latch <= service_grant_latch & ~cur_grp;
      else if (state == ST_IDLE && pick[CHAN_W])
        service_grant_latch <= service_grant_latch | (NCH'(1) << pick_ch);
    end
  end

  // host holds RAM for at most the stall bound
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_busy <= 1'b0;
      stall_cnt <= 2'h0;
      host_ram_grant_o <= 1'b0;
      engine_ram_o <= 1'b0;
      stall_o <= 1'b0;
    end else begin
      // the winning cycle counts toward the stall bound
      if (host_busy)
        host_busy <= stall_cnt < 2'(STALL_MAX_CLKS - 2);
      else
        host_busy <= host_win;
      stall_cnt <= host_busy ? stall_cnt + 2'h1 : 2'h0;
      host_ram_grant_o <= host_win || host_busy;
      engine_ram_o <= eng_want && !eng_stall;
      stall_o <= eng_stall;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      slot <= SLOT_RESET;
      cnt <= '0;
      ram_left <= '0;
      cur <= '0;
      clear_group <= 1'b0;
      pausing <= 1'b0;
      transiting <= 1'b0;
    end else begin
      clear_group <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (pick[CHAN_W]) begin
            state <= ST_SERVICE;
            cur.active <= 1'b1;
            cur.channel <= pick_ch;
            cur.level <= level_i[pick_ch];
            cur.func <= func_i[pick_ch];
            cur.pwm_high <= lvl_s2[pick_ch];
            // stalls extend the state, clocks exclude them
            cnt <= service_clks(func_i[pick_ch],
                                lvl_s2[pick_ch]);
            ram_left <= ram_accesses(func_i[pick_ch], lvl_s2[pick_ch]);
          end
        end
        ST_SERVICE: begin
          if (!eng_stall) begin
            cnt <= cnt - 8'h1;
            if (eng_want) ram_left <= ram_left - 4'h1;
          end
          if (service_done) begin
            cur.active <= 1'b0;
            if (group_idle) begin
              state <= ST_NOP;
              pausing <= 1'b1;
              clear_group <= 1'b1;
              cnt <= CNT_W'(NOP_CLKS);
            end else begin
              state <= ST_TRANS;
              transiting <= 1'b1;
              cnt <= CNT_W'(TRANSITION_CLKS);
            end
          end
        end
        ST_NOP: begin
          cnt <= cnt - 8'h1;
          if (cnt == 8'h1) begin
            state <= ST_TRANS;
            pausing <= 1'b0;
            transiting <= 1'b1;
            cnt <= CNT_W'(TRANSITION_CLKS);
          end
        end
        default: begin
          cnt <= cnt - 8'h1;
          if (cnt == 8'h1) begin
            state <= ST_IDLE;
            transiting <= 1'b0;
            slot <= (slot == 3'(SLOT_COUNT - 1)) ? 3'h0 : slot + 3'h1;
          end
        end
      endcase
    end
  end

  assign grant_o = cur;
  // gap flags kept in their own flops so the outputs carry no decode
  assign nop_o = pausing;
  assign transition_o = transiting;
  assign service_request_latch_o = service_request_latch;
  assign service_grant_latch_o = service_grant_latch;
endmodule

/* test/sched_checker.sv */
/* Port-level assertions for the channel service scheduler.
   Assumes binding to every scheduler instance; one clock domain. */
`timescale 1ns/1ps
module sched_checker
  import sched_pkg::*;
#(
  parameter int NCH = NUM_CHANNELS
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 host_ram_grant_o,
  input wire logic                 engine_ram_o,
  input wire logic                 stall_o,
  input wire sched_pkg::grant_type grant_o,
  input wire logic                 nop_o,
  input wire logic                 transition_o,
  input wire logic [NCH-1:0]       service_request_latch_o,
  input wire logic [NCH-1:0]       service_grant_latch_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int             tcnt, ncnt, scnt, want, len;
  logic [NCH-1:0] prev_srl;
  // stall cycles do not count toward a state's length
  assign len = grant_o.func == FN_PERIOD_PULSE_ACCUMULATE_FUNCTION ? PERIOD_PULSE_ACCUMULATE_FUNCTION_CLKS :
               grant_o.func == FN_DIO  ? DIO_CLKS :
               grant_o.pwm_high ? PWM_HIGH_CLKS : PWM_LOW_CLKS;
  always_ff @(posedge clk_i) begin
    tcnt <= transition_o ? tcnt + 1 : 0;
    ncnt <= nop_o ? ncnt + 1 : 0;
    scnt <= grant_o.active ? scnt + int'(!stall_o) : 0;
    want <= grant_o.active ? len : want;
    prev_srl <= service_request_latch_o;
  end
  a_trans_len:
    assert property ($fell(transition_o) |-> tcnt == TRANSITION_CLKS)
    else $error("transition length wrong");
  a_nop_len:
    assert property ($fell(nop_o) |-> ncnt == NOP_CLKS)
    else $error("pause length wrong");
  a_service_len:
    assert property ($fell(grant_o.active) |-> scnt == want)
    else $error("service length wrong");
  a_service_follow:
    assert property ($fell(grant_o.active) |-> nop_o || transition_o)
    else $error("no gap after service");
  a_nop_then_trans:
    assert property ($fell(nop_o) |-> transition_o)
    else $error("pause not followed by transition");
  a_gap_exclusive:
    assert property (grant_o.active |-> !nop_o && !transition_o)
    else $error("service overlaps gap");
  a_ram_exclusive:
    assert property (!(host_ram_grant_o && engine_ram_o))
    else $error("both sides on ram");
  a_stall_short:
    assert property ($rose(stall_o) |-> ##[1:2] !stall_o)
    else $error("stall too long");
  a_grant_latch:
    assert property ($rose(grant_o.active) |->
      service_grant_latch_o[grant_o.channel] && prev_srl[grant_o.channel])
    else $error("grant without request or latch");
  c_pause: cover property ($fell(nop_o));
  c_stall: cover property ($rose(stall_o));
  c_low: cover property ($rose(grant_o.active) && grant_o.level == PRI_LOW);
endmodule

bind channel_service_scheduler sched_checker #(.NCH(NCH)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .host_ram_grant_o(host_ram_grant_o),
  .engine_ram_o(engine_ram_o), .stall_o(stall_o), .grant_o(grant_o),
  .nop_o(nop_o), .transition_o(transition_o),
  .service_request_latch_o(service_request_latch_o),
  .service_grant_latch_o(service_grant_latch_o));

/* test/host_cpu_model.sv */
/* Host processor sharing the parameter RAM with the engine.
   Assumes grant_i comes from the scheduler on the same clock. */
`timescale 1ns/1ps
module host_cpu_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  input  wire logic grant_i,
  output logic      req_o = 1'b0
);
  // drops the request once served so the engine is not starved
  always @(posedge clk_i) req_o <= !rst_i && en_i && !grant_i;
endmodule

/* test/channel_service_scheduler_tb_top.sv */
/* Self-checking bench for the channel service scheduler.
   Assumes the checker bind and the host model are compiled before it. */
`timescale 1ns/1ps
module channel_service_scheduler_tb_top;
  import sched_pkg::*;
  logic            clk_i, rst_i, host_req, host_gnt, en_host, nop, tr, stall;
  logic            eng_ram;
  logic [15:0]     req, edg, pin, service_request_latch, service_grant_latch;
  prio_type [15:0] lvl;
  func_type [15:0] fn;
  grant_type       g, cur;
  int              num_errors, check_count, cyc, n, ns, na;
  logic [3:0]      exp_ch [8] = '{4'h0, 4'h1, 4'h6, 4'h2,
                                  4'h0, 4'h1, 4'h6, 4'h0};
  channel_service_scheduler dut (.clk_i(clk_i), .rst_i(rst_i),
    .request_i(req), .pwm_edge_i(edg), .pwm_level_i(pin), .level_i(lvl),
    .func_i(fn), .host_ram_req_i(host_req), .host_ram_grant_o(host_gnt),
    .engine_ram_o(eng_ram), .stall_o(stall), .grant_o(g), .nop_o(nop),
    .transition_o(tr), .service_request_latch_o(service_request_latch),
    .service_grant_latch_o(service_grant_latch));
  host_cpu_model host (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_host),
    .grant_i(host_gnt), .req_o(host_req));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input logic c, input string m);
    check_count++;
    if (c !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic init;
    req = '0;
    edg = '0;
    pin = '0;
    en_host = 1'b0;
    for (int i = 0; i < 16; i++) begin
      lvl[i] = PRI_OFF;
      fn[i] = FN_DIO;
    end
    rst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
  endtask
  // waits for the next grant, then counts its busy and stalled cycles
  task automatic next_grant;
    n = 0;
    ns = 0;
    na = 0;
    while (g.active !== 1'b1 && n < 300) begin
      n++;
      @(negedge clk_i);
    end
    chk(n < 300, "no grant");
    cur = g;
    n = 0;
    while (g.active === 1'b1 && n < 300) begin
      n++;
      ns += int'(stall);
      na += int'(eng_ram);
      @(negedge clk_i);
    end
  endtask
  task automatic span(ref logic s);
    n = 0;
    while (s === 1'b1 && n < 300) begin
      n++;
      @(negedge clk_i);
    end
  endtask
  task automatic t_dio;
    init;
    lvl[3] = PRI_MID;
    req[3] = 1'b1;
    @(negedge clk_i);
    req[3] = 1'b0;
    next_grant;
    chk(cur.channel === 4'h3 && cur.level === PRI_MID, "slot pass");
    chk(n === DIO_CLKS, "io state length");
    chk(na === DIO_RAM_ACC, "io ram accesses");
    span(nop);
    chk(n === NOP_CLKS, "pause length");
    span(tr);
    chk(n === TRANSITION_CLKS, "transition length");
  endtask
  task automatic t_pwm;
    init;
    lvl[5] = PRI_HIGH;
    fn[5] = FN_PWM;
    for (int h = 1; h >= 0; h--) begin
      pin[5] = h[0];
      edg[5] = 1'b1;
      @(negedge clk_i);
      edg[5] = 1'b0;
      next_grant;
      chk(cur.channel === 4'h5 && cur.pwm_high === h[0], "pwm request");
      chk(n === (h ? PWM_HIGH_CLKS : PWM_LOW_CLKS), "pwm length");
      if (h) chk(na === PWM_RAM_ACC, "pwm ram accesses");
    end
  endtask
  task automatic t_period_pulse_accumulate_function;
    init;
    lvl[1] = PRI_LOW;
    fn[1] = FN_PERIOD_PULSE_ACCUMULATE_FUNCTION;
    en_host = 1'b1;
    req[1] = 1'b1;
    @(negedge clk_i);
    req[1] = 1'b0;
    next_grant;
    chk(n === PERIOD_PULSE_ACCUMULATE_FUNCTION_CLKS + ns, "accumulate length");
    chk(na === PERIOD_PULSE_ACCUMULATE_FUNCTION_RAM_ACC, "accumulate ram accesses");
    chk(ns <= PERIOD_PULSE_ACCUMULATE_FUNCTION_RAM_ACC * STALL_MAX_CLKS, "stall total");
    en_host = 1'b0;
  endtask
  task automatic t_pattern;
    init;
    lvl[0] = PRI_HIGH;
    lvl[6] = PRI_HIGH;
    lvl[1] = PRI_MID;
    lvl[2] = PRI_LOW;
    req = 16'h0047;
    for (int i = 0; i < 8; i++) begin
      next_grant;
      chk(cur.channel === exp_ch[i], "slot order");
    end
    req = '0;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      results;
    end
  end
  initial begin
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    init;
    t_dio;
    $display("io test done");
    t_pwm;
    $display("pwm test done");
    t_period_pulse_accumulate_function;
    $display("accumulate test done");
    t_pattern;
    $display("pattern test done");
    results;
  end
endmodule
